/* File: src/sswd_pkg.sv */
package sswd_pkg;

  // ****************************************
  // time base
  // ****************************************
  localparam int CLOCK_KHZ      = 20000;
  localparam int TICK_US        = 1000;
  localparam int TICK_CYCLES    = (TICK_US * CLOCK_KHZ) / 1000;
  localparam int CNT_W          = 11;

  // ****************************************
  // periods, in ticks of the time base
  // ****************************************
  localparam int RESET_MS       = 50;
  localparam int SHORT_MS       = 100;
  localparam int LONG_MS        = 1600;
  localparam int ADJ_MS         = 400;
  localparam logic [CNT_W-1:0] RESET_TICKS = CNT_W'(RESET_MS * 1000 / TICK_US);
  localparam logic [CNT_W-1:0] SHORT_TICKS = CNT_W'(SHORT_MS * 1000 / TICK_US);
  localparam logic [CNT_W-1:0] LONG_TICKS  = CNT_W'(LONG_MS * 1000 / TICK_US);
  localparam logic [CNT_W-1:0] ADJ_TICKS   = CNT_W'(ADJ_MS * 1000 / TICK_US);

  // ****************************************
  // timeout select codes
  // ****************************************
  localparam logic [1:0] TSEL_SHORT = 2'h0;
  localparam logic [1:0] TSEL_LONG  = 2'h1;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic       low_line_below;
    logic       main_below_backup;
    logic       power_fail_below;
    logic       wdi_high;
    logic       wdi_low;
    logic       chip_enable_in_n;
    logic [1:0] timeout_sel;
  } sswd_sense_s;

  localparam int SENSE_W = $bits(sswd_sense_s);

  typedef struct packed {
    logic reset_out_n;
    logic reset_out;
    logic low_line_n;
    logic power_fail_warning_n;
    logic chip_enable_out_n;
    logic backup_active;
    logic watchdog_timeout_flag_n;
  } sswd_out_s;

  localparam sswd_out_s OUT_RESET = '{
    reset_out_n:             1'b0,
    reset_out:               1'b1,
    low_line_n:              1'b1,
    power_fail_warning_n:    1'b1,
    chip_enable_out_n:       1'b1,
    backup_active:           1'b0,
    watchdog_timeout_flag_n: 1'b1
  };

  typedef enum logic [1:0] {ST_HOLD, ST_STRETCH, ST_RUN} sswd_state_e;
  typedef enum logic [1:0] {WL_MID, WL_HIGH, WL_LOW} sswd_wlvl_e;

endpackage

/* File: src/sswd_sync.sv */
`timescale 1ns/10ps
module sswd_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_comb
      begin
        meta_next[i] = async_in[i];
        sync_next[i] = meta_reg[i];
      end
    end
  endgenerate

  // two stages; only the second stage is read outside
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule

/* File: src/sswd_tick.sv */
`timescale 1ns/10ps
module sswd_tick #(
  parameter int TICK_CYCLES = sswd_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // time base
  output logic      tick
);

  localparam int CW = $clog2(TICK_CYCLES + 1);

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic          tick_reg;
  logic          tick_next;

  always_comb
  begin
    tick_next  = 1'b0;
    count_next = count_reg + CW'(1);
    if (count_reg == CW'(TICK_CYCLES - 1))
    begin
      count_next = '0;
      tick_next  = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      count_reg <= '0;
      tick_reg  <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      tick_reg  <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule

/* File: src/sswd_top.sv */
`timescale 1ns/10ps
module sswd_top #(
  parameter int                             TICK_CYCLES = sswd_pkg::TICK_CYCLES,
  parameter logic [sswd_pkg::CNT_W-1:0]     RESET_TICKS = sswd_pkg::RESET_TICKS,
  parameter logic [sswd_pkg::CNT_W-1:0]     SHORT_TICKS = sswd_pkg::SHORT_TICKS,
  parameter logic [sswd_pkg::CNT_W-1:0]     LONG_TICKS  = sswd_pkg::LONG_TICKS,
  parameter logic [sswd_pkg::CNT_W-1:0]     ADJ_TICKS   = sswd_pkg::ADJ_TICKS
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // digitised comparator results
  input  wire logic       low_line_sense,
  input  wire logic       main_below_backup,
  input  wire logic       power_fail_sense,
  // three-level watchdog input, already split into two detectors
  input  wire logic       watchdog_toggle_in_high,
  input  wire logic       watchdog_toggle_in_low,
  // timeout select strap
  input  wire logic [1:0] timeout_sel,
  // chip enable gating
  input  wire logic       chip_enable_in_n,
  output logic            chip_enable_out_n,
  // supervisor outputs
  output logic            reset_out_n,
  output logic            reset_out,
  output logic            low_line_n,
  output logic            power_fail_warning_n,
  output logic            backup_active,
  output logic            watchdog_timeout_flag_n
);

  localparam int CW = sswd_pkg::CNT_W;

  // ****************************************
  // input synchronisers and time base
  // ****************************************
  sswd_pkg::sswd_sense_s sense_raw;
  sswd_pkg::sswd_sense_s sense;
  logic                  tick;

  always_comb
  begin
    sense_raw.low_line_below    = low_line_sense;
    sense_raw.main_below_backup = main_below_backup;
    sense_raw.power_fail_below  = power_fail_sense;
    sense_raw.wdi_high          = watchdog_toggle_in_high;
    sense_raw.wdi_low           = watchdog_toggle_in_low;
    sense_raw.chip_enable_in_n  = chip_enable_in_n;
    sense_raw.timeout_sel       = timeout_sel;
  end

  // synchronising costs two clocks of latency; the price of clean sampling
  sswd_sync #(
    .WIDTH    (sswd_pkg::SENSE_W)
  ) u_sync (
    .clock    (clock),
    .reset    (reset),
    .async_in (sense_raw),
    .sync_out (sense)
  );

  sswd_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clock       (clock),
    .reset       (reset),
    .tick        (tick)
  );

  // ****************************************
  // watchdog input decode
  // ****************************************
  sswd_pkg::sswd_wlvl_e lvl;
  logic                 lvl_mid;
  logic                 supply_low;

  always_comb
  begin
    lvl = sswd_pkg::WL_MID;
    if (sense.wdi_high && !sense.wdi_low)
    begin
      lvl = sswd_pkg::WL_HIGH;
    end
    else if (sense.wdi_low && !sense.wdi_high)
    begin
      lvl = sswd_pkg::WL_LOW;
    end
    lvl_mid    = (lvl == sswd_pkg::WL_MID);
    supply_low = sense.low_line_below || sense.main_below_backup;
  end

  // ****************************************
  // state registers
  // ****************************************
  sswd_pkg::sswd_state_e state_reg;
  sswd_pkg::sswd_state_e state_next;
  sswd_pkg::sswd_wlvl_e  lvl_reg;
  sswd_pkg::sswd_wlvl_e  lvl_next;
  logic [CW-1:0]         rst_cnt_reg;
  logic [CW-1:0]         rst_cnt_next;
  logic [CW-1:0]         wd_cnt_reg;
  logic [CW-1:0]         wd_cnt_next;
  logic                  first_long_reg;
  logic                  first_long_next;
  logic                  flag_reg;
  logic                  flag_next;
  logic                  transition;
  logic                  expire;
  logic [CW-1:0]         limit;
  sswd_pkg::sswd_out_s   out_reg;
  sswd_pkg::sswd_out_s   out_next;

  // ****************************************
  // watchdog
  // ****************************************
  always_comb
  begin
    lvl_next   = lvl;
    transition = (lvl != lvl_reg);
    if (first_long_reg || sense.timeout_sel == sswd_pkg::TSEL_LONG)
    begin
      limit = LONG_TICKS;
    end
    else if (sense.timeout_sel == sswd_pkg::TSEL_SHORT)
    begin
      limit = SHORT_TICKS;
    end
    else
    begin
      limit = ADJ_TICKS;
    end
    // mid level holds the count at zero; a supply reset outranks expiry
    expire = (state_reg == sswd_pkg::ST_RUN) && !lvl_mid && !transition && tick
             && (wd_cnt_reg == limit - CW'(1)) && !supply_low;
    if (state_reg != sswd_pkg::ST_RUN || lvl_mid || transition)
    begin
      wd_cnt_next = '0;
    end
    else if (tick)
    begin
      wd_cnt_next = wd_cnt_reg + CW'(1);
    end
    else
    begin
      wd_cnt_next = wd_cnt_reg;
    end
    first_long_next = first_long_reg;
    if (state_reg != sswd_pkg::ST_RUN && state_next == sswd_pkg::ST_RUN)
    begin
      first_long_next = 1'b1;
    end
    else if (transition)
    begin
      first_long_next = 1'b0;
    end
    // expiry wins over any clearing cause in the same cycle
    flag_next = flag_reg;
    if (expire)
    begin
      flag_next = 1'b0;
    end
    else if (transition || sense.low_line_below)
    begin
      flag_next = 1'b1;
    end
  end

  // ****************************************
  // reset sequencer
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      sswd_pkg::ST_HOLD:
      begin
        if (!supply_low)
        begin
          state_next = sswd_pkg::ST_STRETCH;
        end
      end
      sswd_pkg::ST_STRETCH:
      begin
        if (supply_low)
        begin
          state_next = sswd_pkg::ST_HOLD;
        end
        else if (tick && rst_cnt_reg == RESET_TICKS - CW'(1))
        begin
          state_next = sswd_pkg::ST_RUN;
        end
      end
      sswd_pkg::ST_RUN:
      begin
        if (supply_low)
        begin
          state_next = sswd_pkg::ST_HOLD;
        end
        else if (expire)
        begin
          state_next = sswd_pkg::ST_STRETCH;
        end
      end
    endcase
    rst_cnt_next = '0;
    if (state_reg == sswd_pkg::ST_STRETCH && state_next == sswd_pkg::ST_STRETCH)
    begin
      rst_cnt_next = rst_cnt_reg + (tick ? CW'(1) : CW'(0));
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_comb
  begin
    out_next.reset_out_n             = (state_next == sswd_pkg::ST_RUN);
    out_next.reset_out               = (state_next != sswd_pkg::ST_RUN);
    out_next.low_line_n              = !sense.low_line_below;
    out_next.power_fail_warning_n    = !(sense.power_fail_below
                                         || sense.main_below_backup);
    out_next.chip_enable_out_n       = sense.low_line_below
                                       || sense.chip_enable_in_n;
    out_next.backup_active           = sense.main_below_backup;
    out_next.watchdog_timeout_flag_n = flag_next;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_reg      <= sswd_pkg::ST_HOLD;
      lvl_reg        <= sswd_pkg::WL_MID;
      rst_cnt_reg    <= '0;
      wd_cnt_reg     <= '0;
      first_long_reg <= 1'b1;
      flag_reg       <= 1'b1;
      out_reg        <= sswd_pkg::OUT_RESET;
    end
    else
    begin
      state_reg      <= state_next;
      lvl_reg        <= lvl_next;
      rst_cnt_reg    <= rst_cnt_next;
      wd_cnt_reg     <= wd_cnt_next;
      first_long_reg <= first_long_next;
      flag_reg       <= flag_next;
      out_reg        <= out_next;
    end
  end

  assign reset_out_n             = out_reg.reset_out_n;
  assign reset_out               = out_reg.reset_out;
  assign low_line_n              = out_reg.low_line_n;
  assign power_fail_warning_n    = out_reg.power_fail_warning_n;
  assign chip_enable_out_n       = out_reg.chip_enable_out_n;
  assign backup_active           = out_reg.backup_active;
  assign watchdog_timeout_flag_n = out_reg.watchdog_timeout_flag_n;

  // ****************************************
  // checks
  // ****************************************
  supply_reset_a: assert property (@(posedge clock) disable iff (reset)
    supply_low |=> !reset_out_n)
    else $error("reset not asserted under low supply");

  stretch_hold_a: assert property (@(posedge clock) disable iff (reset)
    $fell(supply_low) |=> !reset_out_n [*2])
    else $error("reset released without stretch");

  stretch_end_a: assert property (@(posedge clock) disable iff (reset)
    (state_reg == sswd_pkg::ST_STRETCH && !supply_low && tick
     && rst_cnt_reg == RESET_TICKS - CW'(1)) |=> reset_out_n)
    else $error("reset not released after stretch count");

  expire_pulse_a: assert property (@(posedge clock) disable iff (reset)
    expire |=> !reset_out_n && !watchdog_timeout_flag_n
               && state_reg == sswd_pkg::ST_STRETCH && rst_cnt_reg == '0)
    else $error("timeout did not start reset pulse");

  mid_disable_a: assert property (@(posedge clock) disable iff (reset)
    lvl_mid |-> !expire ##1 (wd_cnt_reg == '0))
    else $error("watchdog active while input floating");
  mid_quiet_a: assert property (@(posedge clock) disable iff (reset)
    (lvl_mid && !supply_low && reset_out_n && flag_reg)
    |=> reset_out_n && watchdog_timeout_flag_n)
    else $error("timeout output while input floating");
  toggle_restart_a: assert property (@(posedge clock) disable iff (reset)
    transition |=> wd_cnt_reg == '0)
    else $error("transition did not restart count");
  pf_warn_a: assert property (@(posedge clock) disable iff (reset)
    (sense.power_fail_below || sense.main_below_backup) |=> !power_fail_warning_n)
    else $error("power fail warning not asserted");
  pf_clear_a: assert property (@(posedge clock) disable iff (reset)
    (!sense.power_fail_below && !sense.main_below_backup) |=> power_fail_warning_n)
    else $error("power fail warning stuck low");
  ce_gate_a: assert property (@(posedge clock) disable iff (reset)
    sense.low_line_below |=> chip_enable_out_n)
    else $error("chip enable passed during low line");
  low_line_a: assert property (@(posedge clock) disable iff (reset)
    !sense.low_line_below |=> low_line_n)
    else $error("low line output delayed");
  backup_follow_a: assert property (@(posedge clock) disable iff (reset)
    backup_active == $past(sense.main_below_backup))
    else $error("backup indication wrong");
  reset_pair_a: assert property (@(posedge clock) disable iff (reset)
    reset_out == !reset_out_n)
    else $error("reset outputs not complementary");
  first_long_a: assert property (@(posedge clock) disable iff (reset)
    (state_reg != sswd_pkg::ST_RUN && state_next == sswd_pkg::ST_RUN)
    |=> first_long_reg && wd_cnt_reg == '0)
    else $error("first interval not long after reset");

  flag_return_a: assert property (@(posedge clock) disable iff (reset)
    (!flag_reg && transition) |=> watchdog_timeout_flag_n)
    else $error("timeout flag not cleared by transition");

endmodule

/* File: bench/sswd_host_model.sv */
`timescale 1ns/10ps
// ****************************************
// host processor servicing the watchdog pin
// ****************************************
module sswd_host_model (
  // clock
  input  wire logic       clock,
  // behaviour: 0 float, 1 hold high, 2 hold low, 3 toggle
  input  wire logic [1:0] mode,
  input  wire logic [7:0] period,
  // pin level detectors
  output logic            watchdog_toggle_in_high,
  output logic            watchdog_toggle_in_low
);
  logic [7:0] gap_reg;

  initial
  begin
    watchdog_toggle_in_high = 1'b0;
    watchdog_toggle_in_low  = 1'b0;
    gap_reg                 = 8'h00;
  end

  // levels move off the sampling edge; a floating pin reads as mid level
  always @(negedge clock)
  begin
    gap_reg <= 8'h00;
    case (mode)
      2'h0: {watchdog_toggle_in_high, watchdog_toggle_in_low} <= 2'h0;
      2'h1: {watchdog_toggle_in_high, watchdog_toggle_in_low} <= 2'h2;
      2'h2: {watchdog_toggle_in_high, watchdog_toggle_in_low} <= 2'h1;
      default:
      begin
        gap_reg <= gap_reg + 8'h01;
        if (gap_reg >= period)
        begin
          gap_reg <= 8'h00;
          // from mid this goes high, otherwise flips level
          {watchdog_toggle_in_high, watchdog_toggle_in_low} <=
            {~watchdog_toggle_in_high, watchdog_toggle_in_high};
        end
      end
    endcase
  end
endmodule

/* File: bench/tb_supply_supervisor_watchdog.sv */
`timescale 1ns/10ps
module tb_supply_supervisor_watchdog;
  // short counts keep the run brief
  localparam int TK    = 4;
  localparam int RT    = 5;
  localparam int ST    = 8;
  localparam int LT    = 20;
  localparam int AT    = 12;
  localparam int PW_LO = (RT - 1) * TK - 6;
  localparam int PW_HI = RT * TK + 6;
  localparam int WATCH = 20000;

  logic       clock;
  logic       reset;
  logic       low_line_sense;
  logic       main_below_backup;
  logic       power_fail_sense;
  logic       watchdog_toggle_in_high;
  logic       watchdog_toggle_in_low;
  logic [1:0] timeout_sel;
  logic       chip_enable_in_n;
  logic       chip_enable_out_n;
  logic       reset_out_n;
  logic       reset_out;
  logic       low_line_n;
  logic       power_fail_warning_n;
  logic       backup_active;
  logic       watchdog_timeout_flag_n;
  logic [1:0] mode;
  logic [7:0] period;
  int         err_count;
  int         compares;

  sswd_top #(
    .TICK_CYCLES (TK),
    .RESET_TICKS (sswd_pkg::CNT_W'(RT)),
    .SHORT_TICKS (sswd_pkg::CNT_W'(ST)),
    .LONG_TICKS  (sswd_pkg::CNT_W'(LT)),
    .ADJ_TICKS   (sswd_pkg::CNT_W'(AT))
  ) sswd_top_i (
    .clock                   (clock),
    .reset                   (reset),
    .low_line_sense          (low_line_sense),
    .main_below_backup       (main_below_backup),
    .power_fail_sense        (power_fail_sense),
    .watchdog_toggle_in_high (watchdog_toggle_in_high),
    .watchdog_toggle_in_low  (watchdog_toggle_in_low),
    .timeout_sel             (timeout_sel),
    .chip_enable_in_n        (chip_enable_in_n),
    .chip_enable_out_n       (chip_enable_out_n),
    .reset_out_n             (reset_out_n),
    .reset_out               (reset_out),
    .low_line_n              (low_line_n),
    .power_fail_warning_n    (power_fail_warning_n),
    .backup_active           (backup_active),
    .watchdog_timeout_flag_n (watchdog_timeout_flag_n)
  );

  sswd_host_model sswd_host_model_i (
    .clock                   (clock),
    .mode                    (mode),
    .period                  (period),
    .watchdog_toggle_in_high (watchdog_toggle_in_high),
    .watchdog_toggle_in_low  (watchdog_toggle_in_low)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_range(input string what, input int lo, input int hi, input int got);
    compares++;
    if (got < lo || got > hi)
    begin
      err_count++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // overrunning the limit makes the following range check fail
  task automatic wait_reset(input logic level, input int limit, output int n);
    n = 0;
    while (reset_out_n !== level && n <= limit)
    begin
      @(negedge clock);
      n++;
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_power_on();
    int n;
    @(negedge clock);
    check("reset_out_n", 1'b0, reset_out_n);
    check("reset_out", 1'b1, reset_out);
    wait_reset(1'b1, 60, n);
    check_range("power-on stretch", PW_LO, PW_HI, n);
    wait_reset(1'b0, 200, n);
    check_range("first interval", LT * TK - 6, LT * TK + 8, n);
    @(negedge clock);
    check("timeout flag", 1'b0, watchdog_timeout_flag_n);
    check("reset_out", 1'b1, reset_out);
    wait_reset(1'b1, 60, n);
    check_range("watchdog pulse", PW_LO, PW_HI, n);
    wait_reset(1'b0, 200, n);
    check_range("interval after pulse", LT * TK - 6, LT * TK + 8, n);
    $display("test power_on done");
  endtask

  task automatic t_select();
    int n;
    int bad;
    int lim[4];
    lim = '{ST, LT, AT, AT};
    for (int s = 0; s < 4; s++)
    begin
      timeout_sel <= 2'(s);
      wait_reset(1'b1, 60, n);
      mode <= watchdog_toggle_in_high ? 2'h2 : 2'h1;
      repeat (6) @(negedge clock);
      check("flag after transition", 1'b1, watchdog_timeout_flag_n);
      mode <= 2'h3;
      bad = 0;
      repeat (200)
      begin
        @(negedge clock);
        if (reset_out_n !== 1'b1)
          bad++;
      end
      check_range("serviced resets", 0, 0, bad);
      // hold the opposite level so the count starts at a known edge
      mode <= watchdog_toggle_in_high ? 2'h2 : 2'h1;
      wait_reset(1'b0, 400, n);
      check_range("timeout period", lim[s] * TK - 6, lim[s] * TK + 8, n);
    end
    $display("test select done");
  endtask

  task automatic t_mid();
    int n;
    int bad;
    mode <= 2'h0;
    wait_reset(1'b1, 60, n);
    repeat (6) @(negedge clock);
    check("flag at mid", 1'b1, watchdog_timeout_flag_n);
    bad = 0;
    repeat (150)
    begin
      @(negedge clock);
      if (reset_out_n !== 1'b1 || watchdog_timeout_flag_n !== 1'b1)
        bad++;
    end
    check_range("mid level timeouts", 0, 0, bad);
    $display("test mid done");
  endtask

  task automatic t_low_line();
    int n;
    chip_enable_in_n <= 1'b0;
    repeat (4) @(negedge clock);
    check("chip enable follows", 1'b0, chip_enable_out_n);
    low_line_sense <= 1'b1;
    repeat (4) @(negedge clock);
    check("low_line_n", 1'b0, low_line_n);
    check("reset_out_n", 1'b0, reset_out_n);
    check("reset_out", 1'b1, reset_out);
    check("chip enable blocked", 1'b1, chip_enable_out_n);
    low_line_sense <= 1'b0;
    repeat (4) @(negedge clock);
    check("low_line_n", 1'b1, low_line_n);
    check("chip enable resumes", 1'b0, chip_enable_out_n);
    check("reset held", 1'b0, reset_out_n);
    wait_reset(1'b1, 60, n);
    check_range("low line stretch", PW_LO - 4, PW_HI - 2, n);
    chip_enable_in_n <= 1'b1;
    $display("test low_line done");
  endtask

  task automatic t_supply();
    int n;
    power_fail_sense <= 1'b1;
    repeat (4) @(negedge clock);
    check("power fail warning", 1'b0, power_fail_warning_n);
    power_fail_sense <= 1'b0;
    repeat (4) @(negedge clock);
    check("power fail warning", 1'b1, power_fail_warning_n);
    main_below_backup <= 1'b1;
    repeat (4) @(negedge clock);
    check("backup_active", 1'b1, backup_active);
    check("warning forced", 1'b0, power_fail_warning_n);
    check("reset_out_n", 1'b0, reset_out_n);
    main_below_backup <= 1'b0;
    repeat (4) @(negedge clock);
    check("backup_active", 1'b0, backup_active);
    check("power fail warning", 1'b1, power_fail_warning_n);
    wait_reset(1'b1, 60, n);
    $display("test supply done");
  endtask

  // ****************************************
  // clock, watchdog and main sequence
  // ****************************************
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial
  begin
    repeat (WATCH) @(posedge clock);
    err_count++;
    $display("MISMATCH run time expected finish seen timeout");
    complete_run();
  end

  initial
  begin
    err_count         = 0;
    compares          = 0;
    reset             = 1'b1;
    low_line_sense    = 1'b0;
    main_below_backup = 1'b0;
    power_fail_sense  = 1'b0;
    timeout_sel       = 2'h0;
    chip_enable_in_n  = 1'b1;
    mode              = 2'h1;
    period            = 8'h0B;
    repeat (4) @(negedge clock);
    reset <= 1'b0;
    t_power_on();
    t_select();
    t_mid();
    t_low_line();
    t_supply();
    complete_run();
  end
endmodule
